// ===== rtl/eac_pkg.sv
`default_nettype none
package eac_pkg;
    // Register offsets in the processor I/O window of this block
    localparam logic [1:0] EAC_OFS_ADDR_LOW = 2'h0;
    localparam logic [1:0] EAC_OFS_ADDR_HIGH = 2'h1;
    localparam logic [1:0] EAC_OFS_DATA = 2'h2;
    localparam logic [1:0] EAC_OFS_CONTROL = 2'h3;

    // Control register field positions and the high address bit
    localparam int EAC_BIT_READ = 0;
    localparam int EAC_BIT_WRITE = 1;
    localparam int EAC_BIT_MASTER = 2;
    localparam int EAC_BIT_IRQ_EN = 3;
    localparam int EAC_BIT_ADDR_HIGH = 8;

    // Storage geometry
    localparam int EAC_ADDR_W = 9;
    localparam int EAC_DATA_W = 8;
    localparam int EAC_DEPTH = 512;

    // Clock and timing
    localparam int EAC_CLK_HZ = 100_000_000;
    localparam int EAC_OSC_HZ = 1_000_000;
    localparam int EAC_OSC_DIV = EAC_CLK_HZ / EAC_OSC_HZ;
    localparam int EAC_DIV_W = 7;
    localparam int EAC_WRITE_TICKS = 8448;
    localparam real EAC_WRITE_TIME_MS = 8.5;
    localparam int EAC_WRITE_CYCLES = EAC_WRITE_TICKS * EAC_OSC_DIV;
    localparam int EAC_TICK_W = 14;
    localparam logic [2:0] EAC_MASTER_CYCLES = 3'h4;
    localparam logic [2:0] EAC_WRITE_STALL = 3'h2;
    localparam logic [2:0] EAC_READ_STALL = 3'h4;

    // Processor I/O request, one per cycle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } eac_io_req_s;

    // Complete state of the controller
    typedef struct packed {
        logic [2:0] sync;
        logic supply;
        logic [EAC_ADDR_W-1:0] addr;
        logic [EAC_DATA_W-1:0] data;
        logic rie;
        logic mwe;
        logic [2:0] mwe_cnt;
        logic wstrobe;
        logic [EAC_DATA_W-1:0] wr_data;
        logic stall;
        logic [2:0] stall_cnt;
        logic [EAC_DIV_W-1:0] div_cnt;
        logic [EAC_TICK_W-1:0] tick_cnt;
        logic irq;
        logic [7:0] rdata;
        logic osc_run;
        logic pd_ok;
    } eac_state_s;

    localparam eac_state_s EAC_STATE_RST = '0;
endpackage
`default_nettype wire

// ===== rtl/eac_controller.sv
// Behaviour
// - Reserved address and control bits read zero
// - Nine-bit address picks one of 512 bytes
// - Data register feeds writes, receives reads
// - Ready interrupt held while write strobe clear
// - Master write enable self-clears after four cycles
// - Strobe without master enable is ignored
// - Strobe within four cycles starts write
// - No storage write during flash programming
// - Write strobe stays set until write done
// - Write lasts 8448 ticks of 1 MHz
// - Write start stalls processor two cycles
// - Read fetches byte, stalls four cycles
// - Busy write blocks reads and address changes
// - Write continues through power-down sleep
// - Write survives reset while supply holds
// - Registers sit in processor I/O space
`default_nettype none
module eac_controller
    import eac_pkg::*;
#(
    parameter int unsigned WRITE_TICKS = EAC_WRITE_TICKS,
    parameter int unsigned OSC_DIV = EAC_OSC_DIV
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire eac_io_req_s io_req,
    input wire logic global_irq_enable,
    input wire logic self_program_enable,
    input wire logic sleep_powerdown,
    input wire logic supply_ok,
    output logic [7:0] io_rdata,
    output logic cpu_stall,
    output logic ready_irq,
    output logic osc_run,
    output logic powerdown_ok
);

    ////////////////////////////////////////////////////////////////////////
    // State and storage

    eac_state_s q;
    eac_state_s next_q;
    eac_state_s norm;
    logic [EAC_DATA_W-1:0] mem [EAC_DEPTH];
    logic ctrl_wr;
    logic wr_start;
    logic rd_accept;
    logic tick;
    logic done;
    logic keep_write;
    logic commit;

    // Readback mux; unused upper bits stay zero
    function automatic logic [7:0] read_mux(input eac_state_s s,
                                            input logic [1:0] ofs);
        logic [7:0] v;
        v = 8'h00;
        case (ofs)
            EAC_OFS_ADDR_LOW: v = s.addr[7:0];
            EAC_OFS_ADDR_HIGH: v = {7'h00, s.addr[EAC_BIT_ADDR_HIGH]};
            EAC_OFS_DATA: v = s.data;
            EAC_OFS_CONTROL:
            begin
                v[EAC_BIT_IRQ_EN] = s.rie;
                v[EAC_BIT_MASTER] = s.mwe;
                v[EAC_BIT_WRITE] = s.wstrobe;
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Request decode

    // I/O register decode
    // Control writes judge the master enable as it stood before them
    assign ctrl_wr = io_req.wr && io_req.addr == EAC_OFS_CONTROL;
    assign wr_start = ctrl_wr && io_req.wdata[EAC_BIT_WRITE] && q.mwe
                      && !q.wstrobe;
    assign rd_accept = ctrl_wr && io_req.wdata[EAC_BIT_READ]
                       && !q.wstrobe && !wr_start;
    assign tick = q.wstrobe
                  && q.div_cnt == EAC_DIV_W'(OSC_DIV - 1);
    assign done = tick && !self_program_enable
                  && q.tick_cnt == EAC_TICK_W'(WRITE_TICKS - 1);
    // reset spares a write only with good supply
    assign keep_write = q.wstrobe && q.supply;
    assign commit = done && (!rst || keep_write);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        norm = q;
        // Supply pin: three flops, change taken when last two agree
        norm.sync = {q.sync[1:0], supply_ok};
        if (q.sync[2] == q.sync[1])
        begin
            norm.supply = q.sync[2];
        end
        if (q.mwe_cnt != 3'h0)
        begin
            norm.mwe_cnt = q.mwe_cnt - 3'h1;
        end
        if (q.stall_cnt != 3'h0)
        begin
            norm.stall_cnt = q.stall_cnt - 3'h1;
        end
        if (io_req.wr)
        begin
            case (io_req.addr)
                EAC_OFS_ADDR_LOW:
                begin
                    if (!q.wstrobe)
                    begin
                        norm.addr[7:0] = io_req.wdata;
                    end
                end
                EAC_OFS_ADDR_HIGH:
                begin
                    if (!q.wstrobe)
                    begin
                        norm.addr[EAC_BIT_ADDR_HIGH] = io_req.wdata[0];
                    end
                end
                EAC_OFS_DATA: norm.data = io_req.wdata;
                EAC_OFS_CONTROL:
                begin
                    norm.rie = io_req.wdata[EAC_BIT_IRQ_EN];
                    // Writing zero leaves a pending master enable alone
                    if (io_req.wdata[EAC_BIT_MASTER])
                    begin
                        norm.mwe_cnt = EAC_MASTER_CYCLES;
                    end
                end
                default: norm.data = q.data;
            endcase
        end
        if (wr_start)
        begin
            norm.wstrobe = 1'b1;
            norm.wr_data = q.data;
            norm.div_cnt = '0;
            norm.tick_cnt = '0;
            norm.stall_cnt = EAC_WRITE_STALL;
        end
        if (rd_accept)
        begin
            norm.data = mem[q.addr];
            norm.stall_cnt = EAC_READ_STALL;
        end
        if (q.wstrobe)
        begin
            norm.div_cnt = tick ? '0 : q.div_cnt + EAC_DIV_W'(1);
            if (tick && !self_program_enable)
            begin
                norm.tick_cnt = q.tick_cnt + EAC_TICK_W'(1);
            end
        end
        if (done)
        begin
            norm.wstrobe = 1'b0;
        end
        norm.mwe = norm.mwe_cnt != 3'h0;
        norm.stall = norm.stall_cnt != 3'h0;
        norm.irq = norm.rie && global_irq_enable && !norm.wstrobe;
        // oscillator kept alive by a write, sleep or not
        norm.osc_run = norm.wstrobe;
        norm.pd_ok = sleep_powerdown && !norm.wstrobe;
        norm.rdata = io_req.rd ? read_mux(q, io_req.addr) : 8'h00;

        next_q = norm;
        if (rst)
        begin
            next_q = EAC_STATE_RST;
            next_q.sync = norm.sync;
            // Supply keeps tracking in reset, so a dying write is dropped
            next_q.supply = norm.supply;
            if (keep_write)
            begin
                next_q.addr = q.addr;
                next_q.wr_data = q.wr_data;
                next_q.wstrobe = norm.wstrobe;
                next_q.div_cnt = norm.div_cnt;
                next_q.tick_cnt = norm.tick_cnt;
                next_q.osc_run = norm.wstrobe;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge core_clk)
    begin
        q <= next_q;
    end

    always_ff @(posedge core_clk)
    begin
        if (commit)
        begin
            mem[q.addr] <= q.wr_data;
        end
    end

    // Outputs are plain flops of the state
    assign io_rdata = q.rdata;
    assign cpu_stall = q.stall;
    assign ready_irq = q.irq;
    assign osc_run = q.osc_run;
    assign powerdown_ok = q.pd_ok;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    // One clock domain, so one default clock for all checks
    default clocking cb @(posedge core_clk); endclocking
    // Reset-time checks further down switch this off themselves
    default disable iff (rst);

    a_master_hold: assert property ($rose(q.mwe) |-> q.mwe[*4])
        else $error("master enable dropped early");
    a_master_expire: assert property (
        q.mwe_cnt == 3'h1 && !ctrl_wr |=> !q.mwe)
        else $error("master enable failed to expire");
    a_strobe_ignored: assert property (
        ctrl_wr && io_req.wdata[EAC_BIT_WRITE] && !q.mwe && !q.wstrobe
        |=> !q.wstrobe)
        else $error("write started without master enable");
    a_write_start: assert property (
        wr_start |=> q.wstrobe && q.wr_data == $past(q.data))
        else $error("write did not start");
    a_write_stall: assert property (
        wr_start |=> q.stall[*2] ##1 !q.stall)
        else $error("write stall not two cycles");
    a_read_stall: assert property (
        rd_accept |=> q.stall[*4] ##1 !q.stall)
        else $error("read stall not four cycles");
    a_stall_unasked: assert property (
        !ctrl_wr && q.stall_cnt == 3'h0 |=> !q.stall)
        else $error("stall without a strobe");
    a_read_data: assert property (
        rd_accept |=> q.data == mem[$past(q.addr)])
        else $error("read data wrong");
    a_addr_frozen: assert property (
        q.wstrobe && io_req.wr && io_req.addr != EAC_OFS_DATA
        && io_req.addr != EAC_OFS_CONTROL |=> $stable(q.addr))
        else $error("address changed during write");
    a_busy_no_read: assert property (
        q.wstrobe && ctrl_wr |=> $stable(q.data))
        else $error("read accepted while busy");
    a_strobe_end: assert property (
        $fell(q.wstrobe) |-> $past(q.tick_cnt)
        == EAC_TICK_W'(WRITE_TICKS - 1))
        else $error("write ended at wrong tick");
    a_flash_pause: assert property (
        q.wstrobe && self_program_enable |=> $stable(q.tick_cnt))
        else $error("write timer ran during flash programming");
    a_strobe_hold: assert property (
        q.wstrobe && !done |=> q.wstrobe)
        else $error("write strobe dropped early");
    a_irq_level: assert property (
        q.rie && global_irq_enable && !q.wstrobe && !io_req.wr
        |=> q.irq)
        else $error("ready interrupt missing");
    a_irq_busy: assert property (
        q.wstrobe && !done |=> !q.irq)
        else $error("ready interrupt during write");
    a_ctrl_reserved: assert property (
        io_req.rd && io_req.addr == EAC_OFS_CONTROL
        |=> q.rdata[7:4] == 4'h0 && !q.rdata[EAC_BIT_READ])
        else $error("reserved control bits set");
    a_addr_reserved: assert property (
        io_req.rd && io_req.addr == EAC_OFS_ADDR_HIGH
        |=> q.rdata[7:1] == 7'h00)
        else $error("reserved address bits set");
    a_osc_sleep: assert property (
        q.wstrobe && sleep_powerdown |=> !q.pd_ok || !q.wstrobe)
        else $error("power-down reached during write");
    a_commit_data: assert property (
        commit |=> mem[$past(q.addr)] == $past(q.wr_data))
        else $error("stored byte wrong");

    a_reset_keeps: assert property (
        disable iff (1'b0) rst && keep_write && !done |=> q.wstrobe)
        else $error("write lost across reset");

    // Main scenarios worth seeing
    c_write_done: cover property ($fell(q.wstrobe));
    c_read_done: cover property (rd_accept ##5 !q.stall);
    c_strobe_late: cover property (
        ctrl_wr && io_req.wdata[EAC_BIT_WRITE] && !q.mwe && !q.wstrobe);
    c_flash_pause: cover property (tick && self_program_enable);
    c_reset_keep: cover property (disable iff (1'b0) rst && keep_write);

endmodule
`default_nettype wire

// ===== tb/eeprom_access_controller_tb.sv
`default_nettype none
module eeprom_access_controller_tb
    import eac_pkg::*;
;
timeunit 1ns;
timeprecision 1ps;
// Short timing so a write lasts tens of cycles
localparam int TK = 4;
localparam int DV = 8;
localparam int WR = TK * DV;
localparam logic [1:0] AL = EAC_OFS_ADDR_LOW;
localparam logic [1:0] AH = EAC_OFS_ADDR_HIGH;
localparam logic [1:0] DT = EAC_OFS_DATA;
localparam logic [1:0] CT = EAC_OFS_CONTROL;
logic core_clk, rst, gie, spe, slp, sup, stall, irq, osc, pdok;
eac_io_req_s req;
logic [7:0] rdata;
int fail_count, num_checks, cyc, n_st, n_osc;
eac_controller #(.WRITE_TICKS(TK), .OSC_DIV(DV)) i_eac_controller (
    .core_clk(core_clk), .rst(rst), .io_req(req),
    .global_irq_enable(gie), .self_program_enable(spe),
    .sleep_powerdown(slp), .supply_ok(sup), .io_rdata(rdata),
    .cpu_stall(stall), .ready_irq(irq), .osc_run(osc),
    .powerdown_ok(pdok));
////////////////////////////////////////////////////////////////////////
// Clock generator
initial
begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
end
// Stall and busy counters, plus the hang guard
always @(posedge core_clk)
begin
    if (stall) n_st++;
    if (osc) n_osc++;
    cyc++;
    if (cyc == 3000)
    begin
        fail_count++;
        final_report();
    end
end
////////////////////////////////////////////////////////////////////////
task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
endtask
// One-cycle register write pulse
task automatic wr(logic [1:0] a, logic [7:0] d);
    tick(1);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick(1);
    req.wr = 1'b0;
endtask
task automatic chk(string s, logic [7:0] got, logic [7:0] e);
    num_checks++;
    if (got !== e)
    begin
        fail_count++;
        $display("MISMATCH %s exp %h got %h", s, e, got);
    end
endtask
// Read data is taken in the cycle after the strobe edge
task automatic rdck(logic [1:0] a, logic [7:0] e);
    tick(1);
    req.rd = 1'b1;
    req.addr = a;
    tick(1);
    req.rd = 1'b0;
    chk("reg", rdata, e);
endtask
// Full write sequence; c carries the interrupt enable bit
task automatic nvwr(logic [8:0] a, logic [7:0] d, logic [7:0] c);
    wr(AH, {7'h00, a[8]});
    wr(AL, a[7:0]);
    wr(DT, d);
    wr(CT, c | 8'h04);
    n_st = 0;
    n_osc = 0;
    wr(CT, c | 8'h02);
endtask
task automatic nvrd(logic [8:0] a, logic [7:0] e);
    wr(AH, {7'h00, a[8]});
    wr(AL, a[7:0]);
    n_st = 0;
    wr(CT, 8'h01);
    tick(4);
    rdck(DT, e);
endtask
// Bounded wait, a flash programming pause makes the exact length vary
task automatic wait_idle;
    int i;
    i = 0;
    while (osc && i < 300)
    begin
        tick(1);
        i++;
    end
    chk("idle", osc, 8'h00);
endtask
task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
// Main sequence
initial
begin
    {rst, gie, spe, slp, sup} = 5'b10000;
    req = '0;
    {n_st, n_osc, cyc, fail_count, num_checks} = '0;
    repeat (8) @(posedge core_clk);
    #1;
    sup = 1'b1;
    rst = 1'b0;
    rdck(CT, 8'h00);
    wr(AH, 8'hFF);
    rdck(AH, 8'h01);
    wr(CT, 8'hF0);
    rdck(CT, 8'h00);
    wr(CT, 8'h02);
    rdck(CT, 8'h00);
    chk("busy", osc, 8'h00);
    $display("test reserved and lone strobe done");
    gie = 1'b1;
    slp = 1'b1;
    wr(CT, 8'h08);
    tick(2);
    chk("irq idle", irq, 8'h01);
    nvwr(9'h1FF, 8'hA5, 8'h08);
    tick(1);
    chk("irq busy", irq, 8'h00);
    chk("pd busy", pdok, 8'h00);
    rdck(CT, 8'h0A);
    chk("wr stall", 8'(n_st), 8'h02);
    // Busy write must block address change and read strobe
    wr(AL, 8'h00);
    wr(DT, 8'h3C);
    wr(CT, 8'h09);
    rdck(DT, 8'h3C);
    rdck(AL, 8'hFF);
    wait_idle();
    chk("wr time", 8'(n_osc >= WR && n_osc <= WR + DV), 8'h01);
    tick(1);
    chk("irq done", irq, 8'h01);
    chk("pd done", pdok, 8'h01);
    rdck(CT, 8'h08);
    nvrd(9'h1FF, 8'hA5);
    chk("rd stall", 8'(n_st), 8'h04);
    wr(CT, 8'h08);
    gie = 1'b0;
    slp = 1'b0;
    tick(2);
    chk("irq gated", irq, 8'h00);
    $display("test write read irq done");
    wr(CT, 8'h0C);
    rdck(CT, 8'h0C);
    tick(4);
    rdck(CT, 8'h08);
    wr(CT, 8'h0A);
    tick(1);
    chk("late strobe", osc, 8'h00);
    $display("test master timeout done");
    nvwr(9'h000, 8'h5A, 8'h00);
    spe = 1'b1;
    tick(WR + 10);
    chk("paused", osc, 8'h01);
    rdck(CT, 8'h02);
    spe = 1'b0;
    wait_idle();
    nvrd(9'h000, 8'h5A);
    nvrd(9'h1FF, 8'hA5);
    $display("test flash pause done");
    nvwr(9'h155, 8'hC3, 8'h00);
    tick(5);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    chk("kept", osc, 8'h01);
    rdck(CT, 8'h02);
    wait_idle();
    nvrd(9'h155, 8'hC3);
    $display("test reset in write done");
    final_report();
end
endmodule
`default_nettype wire
